// ### shared/amd_defines.vh
// constants for the processor address map decoder and interrupt fan-out
// assumes a single core clock; no software-visible registers in this block
//
// Notes on behaviour
// (RULE1) every irq goes to both interrupt controllers
// (RULE2) any routed irq wakes retention deep sleep
// (RULE3) no non-maskable interrupt input or output exists
// (RULE4) priority fields are three bits, eight levels
// (RULE5) vector base relocatable, handler fetch follows it
// (RULE6) 0x40000000 region is peripheral, not executable
// (RULE7) 0x60000000 external memory allows instruction fetch
// (RULE8) lower private window stays inside processor
// (RULE9) upper private window goes out as APB
// (RULE10) fetch from private or vendor region faults
// (RULE11) software keeps vector table out of private region
// (RULE12) vendor region data goes on system bus
// (RULE13) protection unit has at most eight regions
// (RULE14) no match or permission breach raises fault
// (RULE15) check core and system protection attributes both
// (RULE16) three separate AHB master ports are used
// (RULE17) code space fetches use instruction code bus
// (RULE18) code space data and debug use data bus
// (RULE19) SRAM and peripherals go on system bus
// (RULE20) SRAM also decoded at alias in code space
// (RULE21) APB bridge adds exactly one wait state
// (RULE22) reserved and device region fetches also fault
`ifndef AMD_DEFINES_VH
`define AMD_DEFINES_VH

// ----------------------------------------------------------------
// address map, full 32-bit addresses compared against region bases
// ----------------------------------------------------------------
`define AMD_CODE_BASE 32'h00000000
`define AMD_RSVD_BASE 32'h20000000
`define AMD_PERIPH_BASE 32'h40000000
`define AMD_EXTRAM_BASE 32'h60000000
`define AMD_EXTDEV_BASE 32'hA0000000
`define AMD_PPB_BASE 32'hE0000000
`define AMD_PPB_INT_LAST 32'hE0043FFF
`define AMD_PPB_EXT_BASE 32'hE0044000
`define AMD_VENDOR_BASE 32'hE0100000
`define AMD_SRAM_BASE 32'h20000000
`define AMD_SRAM_SIZE 32'h00100000
`define AMD_ALIAS_BASE 32'h10000000
`define AMD_APB_BASE 32'h40000000
`define AMD_APB_LAST 32'h4FFFFFFF

// ----------------------------------------------------------------
// route select bit positions (one-hot)
// ----------------------------------------------------------------
`define AMD_RT_INSTRUCTION_CODE_BUS 0
`define AMD_RT_DATA_CODE_BUS 1
`define AMD_RT_SYS 2
`define AMD_RT_PPBINT 3
`define AMD_RT_EXTERNAL_PRIVATE_PERIPH_PORT 4
`define AMD_RT_W 5

// ----------------------------------------------------------------
// region attribute field positions
// ----------------------------------------------------------------
`define AMD_ATTR_XN 0
`define AMD_ATTR_RO 1
`define AMD_ATTR_PRIV 2
`define AMD_ATTR_W 3
`define AMD_NUM_RGN 8

// ----------------------------------------------------------------
// interrupt fabric
// ----------------------------------------------------------------
`define AMD_NUM_IRQ 32
`define AMD_IRQ_IDW 5
`define AMD_PRIO_W 3
`define AMD_EXC_OFFSET 16
`define AMD_APB_WAITS 1

`endif

// ### src/amd_decoder.v
// address map decoder, bus router, fetch guard and interrupt fan-out
// assumes requester and peripherals run on mclk; one request in flight
`timescale 1ns/1ps
`include "amd_defines.vh"

module amd_decoder
(
  mclk,
  rstn,
  ce,
  reqValid,
  reqAddr,
  reqFetch,
  reqWrite,
  reqPriv,
  reqDebug,
  sysProtDeny,
  mpuEnable,
  rgnEnable,
  rgnBase,
  rgnLast,
  rgnAttr,
  irqIn,
  irqPrio,
  vecBase,
  deepSleep,
  reqReady,
  routeValid,
  routeSel,
  routeAddr,
  sramAlias,
  accessDone,
  faultFetch,
  faultMpu,
  faultSys,
  nvicIrq,
  wakeIrq,
  wakeReq,
  irqPending,
  irqBestId,
  irqBestPrio,
  vecFetchAddr
);
  input wire mclk;
  input wire rstn;
  input wire ce;
  input wire reqValid;
  input wire [31:0] reqAddr;
  input wire reqFetch;
  input wire reqWrite;
  input wire reqPriv;
  input wire reqDebug;
  input wire sysProtDeny;
  input wire mpuEnable;
  input wire [`AMD_NUM_RGN-1:0] rgnEnable;
  input wire [32*`AMD_NUM_RGN-1:0] rgnBase;
  input wire [32*`AMD_NUM_RGN-1:0] rgnLast;
  input wire [`AMD_ATTR_W*`AMD_NUM_RGN-1:0] rgnAttr;
  input wire [`AMD_NUM_IRQ-1:0] irqIn;
  input wire [`AMD_PRIO_W*`AMD_NUM_IRQ-1:0] irqPrio;
  input wire [31:0] vecBase;
  input wire deepSleep;
  output reg reqReady;
  output reg routeValid;
  output reg [`AMD_RT_W-1:0] routeSel;
  output reg [31:0] routeAddr;
  output reg sramAlias;
  output reg accessDone;
  output reg faultFetch;
  output reg faultMpu;
  output reg faultSys;
  output reg [`AMD_NUM_IRQ-1:0] nvicIrq;
  output reg [`AMD_NUM_IRQ-1:0] wakeIrq;
  output reg wakeReq;
  output reg irqPending;
  output reg [`AMD_IRQ_IDW-1:0] irqBestId;
  output reg [`AMD_PRIO_W-1:0] irqBestPrio;
  output reg [31:0] vecFetchAddr;

  // ----------------------------------------------------------------
  // access state machine
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;

  // ----------------------------------------------------------------
  // protection unit: eight comparators, highest index wins
  // ----------------------------------------------------------------
  wire [`AMD_NUM_RGN-1:0] rgnHit;
  wire [`AMD_NUM_RGN-1:0] rgnBreach;
  reg mpuMatch;
  reg mpuViol;
  integer r;

  genvar g;
  generate
    for (g = 0; g < `AMD_NUM_RGN; g = g + 1)
    begin : gRgn
      amd_region_check uCheck
      (
        .enable(rgnEnable[g]),
        .baseAddr(rgnBase[32*g+31:32*g]),
        .lastAddr(rgnLast[32*g+31:32*g]),
        .attr(rgnAttr[`AMD_ATTR_W*g+`AMD_ATTR_W-1:`AMD_ATTR_W*g]),
        .addr(reqAddr),
        .isFetch(reqFetch),
        .isWrite(reqWrite),
        .isPriv(reqPriv),
        .hit(rgnHit[g]),
        .breach(rgnBreach[g])
      );
    end
  endgenerate

  // overlapping regions: later region overrides earlier, as is usual
  always @*
  begin
    mpuMatch = 1'b0;
    mpuViol = 1'b0;
    for (r = 0; r < `AMD_NUM_RGN; r = r + 1) // RULE13
    begin
      if (rgnHit[r])
      begin
        mpuMatch = 1'b1;
        mpuViol = rgnBreach[r];
      end
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  reg inCode;
  reg inRsvd;
  reg inPeriph;
  reg inExtRam;
  reg inExtDev;
  reg inPpbInt;
  reg inPpbExt;
  reg inVendor;
  reg inAlias;
  reg inApb;
  reg nonExec;
  reg mpuFault;
  reg anyFault;
  reg [`AMD_RT_W-1:0] selD;
  reg [31:0] addrD;

  always @*
  begin
    inCode = 1'b0;
    inRsvd = 1'b0;
    inPeriph = 1'b0;
    inExtRam = 1'b0;
    inExtDev = 1'b0;
    inPpbInt = 1'b0;
    inPpbExt = 1'b0;
    inVendor = 1'b0;
    if (reqAddr >= `AMD_VENDOR_BASE)
      inVendor = 1'b1;
    else if (reqAddr >= `AMD_PPB_EXT_BASE)
      inPpbExt = 1'b1;
    else if (reqAddr >= `AMD_PPB_BASE)
      inPpbInt = 1'b1;
    else if (reqAddr >= `AMD_EXTDEV_BASE)
      inExtDev = 1'b1;
    else if (reqAddr >= `AMD_EXTRAM_BASE)
      inExtRam = 1'b1;
    else if (reqAddr >= `AMD_PERIPH_BASE)
      inPeriph = 1'b1;
    else if (reqAddr >= `AMD_RSVD_BASE)
      inRsvd = 1'b1;
    else
      inCode = 1'b1;
    inAlias = inCode && (reqAddr >= `AMD_ALIAS_BASE) &&
              (reqAddr < `AMD_ALIAS_BASE + `AMD_SRAM_SIZE); // RULE20
    inApb = inPeriph && (reqAddr <= `AMD_APB_LAST);
    // external RAM and code stay executable
    nonExec = inRsvd || inPeriph || inExtDev || // RULE6 RULE22
              inPpbInt || inPpbExt || inVendor; // RULE10 RULE7
    mpuFault = mpuEnable && (!mpuMatch || mpuViol); // RULE14
    anyFault = (reqFetch && nonExec) || mpuFault || sysProtDeny; // RULE15
  end

  always @*
  begin
    selD = {`AMD_RT_W{1'b0}};
    addrD = reqAddr;
    if (inCode && reqFetch && !reqDebug)
      selD[`AMD_RT_INSTRUCTION_CODE_BUS] = 1'b1; // RULE17
    else if (inCode)
      selD[`AMD_RT_DATA_CODE_BUS] = 1'b1; // RULE18
    else if (inPpbInt)
      selD[`AMD_RT_PPBINT] = 1'b1; // RULE8
    else if (inPpbExt)
      selD[`AMD_RT_EXTERNAL_PRIVATE_PERIPH_PORT] = 1'b1; // RULE9
    else
      selD[`AMD_RT_SYS] = 1'b1; // RULE12 RULE19
    // alias keeps its code-bus route but targets the SRAM array
    if (inAlias)
      addrD = reqAddr - `AMD_ALIAS_BASE + `AMD_SRAM_BASE; // RULE20
  end

  // ----------------------------------------------------------------
  // access sequencing
  // ----------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (reqValid && reqReady && !anyFault && inApb)
          state_d = ST_WAIT; // RULE21
      ST_WAIT:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // three separate master ports: instruction_code_bus, data_code_bus and system selects
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      reqReady <= 1'b0;
      routeValid <= 1'b0;
      routeSel <= {`AMD_RT_W{1'b0}};
      routeAddr <= 32'h00000000;
      sramAlias <= 1'b0;
      accessDone <= 1'b0;
      faultFetch <= 1'b0;
      faultMpu <= 1'b0;
      faultSys <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      routeValid <= 1'b0;
      accessDone <= 1'b0;
      faultFetch <= 1'b0;
      faultMpu <= 1'b0;
      faultSys <= 1'b0;
      reqReady <= (state_d == ST_IDLE);
      case (state_q)
        ST_IDLE:
          if (reqValid && reqReady)
          begin
            // a faulting access is never issued on any port
            if (anyFault)
            begin
              routeSel <= {`AMD_RT_W{1'b0}}; // RULE14
              faultFetch <= reqFetch && nonExec; // RULE10
              faultMpu <= mpuFault;
              faultSys <= sysProtDeny; // RULE15
              accessDone <= 1'b1;
            end
            else
            begin
              routeValid <= 1'b1; // RULE16
              routeSel <= selD;
              routeAddr <= addrD;
              sramAlias <= inAlias;
              accessDone <= !inApb; // RULE21
            end
          end
        ST_WAIT:
          accessDone <= 1'b1; // RULE21
        default:
          accessDone <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt fan-out and priority pick
  // ----------------------------------------------------------------
  reg found;
  reg [`AMD_IRQ_IDW-1:0] bestId;
  reg [`AMD_PRIO_W-1:0] bestPrio;
  reg [`AMD_PRIO_W-1:0] thisPrio;
  integer i;

  // lower value is more urgent; ties go to the lower line number
  always @*
  begin
    found = 1'b0;
    bestId = {`AMD_IRQ_IDW{1'b0}};
    bestPrio = {`AMD_PRIO_W{1'b1}};
    thisPrio = {`AMD_PRIO_W{1'b0}};
    for (i = 0; i < `AMD_NUM_IRQ; i = i + 1)
    begin
      thisPrio = irqPrio[`AMD_PRIO_W*i +: `AMD_PRIO_W]; // RULE4
      if (irqIn[i] && (!found || thisPrio < bestPrio))
      begin
        found = 1'b1;
        bestId = i[`AMD_IRQ_IDW-1:0];
        bestPrio = thisPrio;
      end
    end
  end

  // no nmi line exists: every source is maskable
  always @(posedge mclk)
  begin
    if (!rstn)
    begin
      nvicIrq <= {`AMD_NUM_IRQ{1'b0}};
      wakeIrq <= {`AMD_NUM_IRQ{1'b0}};
      wakeReq <= 1'b0;
      irqPending <= 1'b0;
      irqBestId <= {`AMD_IRQ_IDW{1'b0}};
      irqBestPrio <= {`AMD_PRIO_W{1'b0}};
      vecFetchAddr <= 32'h00000000;
    end
    else if (ce)
    begin
      nvicIrq <= irqIn; // RULE1 RULE3
      wakeIrq <= irqIn; // RULE1
      wakeReq <= deepSleep && (|irqIn); // RULE2
      irqPending <= found;
      irqBestId <= bestId;
      irqBestPrio <= bestPrio; // RULE4
      // base assumed outside the private window by software RULE11
      vecFetchAddr <= vecBase +
        {24'h000000, {1'b0, bestId} + 6'h10, 2'b00}; // RULE5
    end
  end
endmodule // amd_decoder

// ### src/amd_region_check.v
// one protection region comparator: hit and permission breach
// assumes base and last are inclusive byte addresses set by software
`timescale 1ns/1ps
`include "amd_defines.vh"

module amd_region_check
(
  enable,
  baseAddr,
  lastAddr,
  attr,
  addr,
  isFetch,
  isWrite,
  isPriv,
  hit,
  breach
);
  input wire enable;
  input wire [31:0] baseAddr;
  input wire [31:0] lastAddr;
  input wire [`AMD_ATTR_W-1:0] attr;
  input wire [31:0] addr;
  input wire isFetch;
  input wire isWrite;
  input wire isPriv;
  output wire hit;
  output wire breach;

  assign hit = enable && (addr >= baseAddr) && (addr <= lastAddr);
  assign breach = (isFetch && attr[`AMD_ATTR_XN]) ||
                  (isWrite && attr[`AMD_ATTR_RO]) ||
                  (!isPriv && attr[`AMD_ATTR_PRIV]);
endmodule // amd_region_check

// ### testbench/amd_decoder_monitor.sv
// assertions on the address decoder's top ports
// assumes ce goes low only while no request is offered
`timescale 1ns/1ps
`include "amd_defines.vh"

module amd_decoder_monitor
(
  input wire mclk,
  input wire rstn,
  input wire ce,
  input wire reqValid,
  input wire [31:0] reqAddr,
  input wire reqFetch,
  input wire reqDebug,
  input wire sysProtDeny,
  input wire mpuEnable,
  input wire [`AMD_NUM_IRQ-1:0] irqIn,
  input wire deepSleep,
  input wire reqReady,
  input wire routeValid,
  input wire [`AMD_RT_W-1:0] routeSel,
  input wire accessDone,
  input wire faultFetch,
  input wire [`AMD_NUM_IRQ-1:0] nvicIrq,
  input wire [`AMD_NUM_IRQ-1:0] wakeIrq,
  input wire wakeReq
);
  // --------
  // map and interrupt checks
  // --------
  // protection off, so only the map decides
  wire tk = reqValid && reqReady && !mpuEnable && !sysProtDeny;
  wire fe = tk && reqFetch;
  wire da = tk && !reqFetch;
  wire [31:0] a = reqAddr;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_IRQ_FAN: assert property ($past(rstn) && $past(ce) |->
    nvicIrq == $past(irqIn) && wakeIrq == nvicIrq) else $error("fan");
  AST_WAKE: assert property ($past(rstn) && $past(ce) |->
    wakeReq == $past(deepSleep && |irqIn)) else $error("wake");
  AST_PERIPH_XN: assert property (fe && a[31:29] == 3'h2 |=>
    accessDone && faultFetch) else $error("periph fetch");
  AST_EXTRAM_X: assert property (fe && a[31:28] >= 4'h6 &&
    a[31:28] <= 4'h9 |=> routeValid && !faultFetch) else $error("xram");
  AST_PPB_INT: assert property (da && a >= 32'hE0000000 &&
    a <= 32'hE0043FFF |=> routeSel == 5'h08) else $error("ppb int");
  AST_PPB_EXT: assert property (da && a >= 32'hE0044000 &&
    a <= 32'hE00FFFFF |=> routeSel == 5'h10) else $error("ppb ext");
  AST_FETCH_SYS: assert property (fe && a >= 32'hE0000000 |=>
    faultFetch && routeSel == 5'h00) else $error("sys fetch");
  AST_VENDOR: assert property (da && a >= 32'hE0100000 |=>
    routeValid && routeSel == 5'h04) else $error("vendor");
  AST_ONEHOT: assert property (routeValid |->
    $onehot(routeSel)) else $error("onehot");
  AST_INSTRUCTION_CODE_BUS: assert property (fe && !reqDebug &&
    a < 32'h20000000 |=> routeSel == 5'h01) else $error("instruction_code_bus");
  AST_DATA_CODE_BUS: assert property (tk && a < 32'h20000000 &&
    (!reqFetch || reqDebug) |=> routeSel == 5'h02) else $error("data_code_bus");
  AST_APB: assert property (da && a[31:28] == 4'h4 |=>
    routeValid && !reqReady && !accessDone ##1 accessDone && reqReady)
    else $error("apb wait");
  AST_RSVD_XN: assert property (fe && (a[31:29] == 3'h1 ||
    a[31:29] == 3'h5 || a[31:29] == 3'h6) |=> faultFetch)
    else $error("xn fetch");

  cover property (fe ##1 faultFetch);
  cover property (wakeReq);
  cover property (routeValid && routeSel[4]);
endmodule // amd_decoder_monitor

bind amd_decoder amd_decoder_monitor amd_decoder_monitor_inst (
  .mclk(mclk), .rstn(rstn), .ce(ce), .reqValid(reqValid),
  .reqAddr(reqAddr),
  .reqFetch(reqFetch), .reqDebug(reqDebug), .sysProtDeny(sysProtDeny),
  .mpuEnable(mpuEnable), .irqIn(irqIn), .deepSleep(deepSleep),
  .reqReady(reqReady), .routeValid(routeValid), .routeSel(routeSel),
  .accessDone(accessDone), .faultFetch(faultFetch), .nvicIrq(nvicIrq),
  .wakeIrq(wakeIrq), .wakeReq(wakeReq));

// ### testbench/amd_memctl_model.sv
// memory controller protection model: denies one guarded window
// assumes the bench feeds it the requested address
`timescale 1ns/1ps

module amd_memctl_model
#(
  parameter DENY_BASE = 32'h200F0000,
  parameter DENY_LAST = 32'h200FFFFF
)
(
  input wire [31:0] reqAddr,
  output wire sysProtDeny
);
  // judged apart from the core's own regions
  assign sysProtDeny = reqAddr >= DENY_BASE && reqAddr <= DENY_LAST;
endmodule // amd_memctl_model

// ### testbench/test_amd_decoder.sv
// self-checking bench for the address decoder
// assumes one 200 MHz clock and the memory controller model
`timescale 1ns/1ps
`include "amd_defines.vh"

module test_amd_decoder;
  localparam [8:0] IC = 9'h010, DC = 9'h020, SY = 9'h040, PI = 9'h080;
  localparam [8:0] PE = 9'h100, AL = 9'h008, FF = 9'h004, FM = 9'h002;
  localparam [8:0] FS = 9'h001;
  reg mclk = 1'h0, rstn = 1'h0, reqValid = 1'h0, reqFetch = 1'h0;
  reg reqWrite = 1'h0, reqDebug = 1'h0, mpuEnable = 1'h0, deepSleep = 1'h0;
  reg reqPriv = 1'h1, ce = 1'h1;
  reg [31:0] reqAddr = 32'h0, vecBase = 32'h0, irqIn = 32'h0;
  reg [7:0] rgnEnable = 8'h0;
  reg [255:0] rgnBase = 256'h0, rgnLast = 256'h0;
  reg [23:0] rgnAttr = 24'h0;
  reg [95:0] irqPrio = 96'h0;
  wire sysProtDeny, reqReady, routeValid, sramAlias, accessDone, faultFetch;
  wire faultMpu, faultSys, wakeReq, irqPending;
  wire [4:0] routeSel, irqBestId;
  wire [2:0] irqBestPrio;
  wire [31:0] routeAddr, nvicIrq, wakeIrq, vecFetchAddr;
  integer nErrors = 0, cmpCount = 0, cyc = 0, i;
  reg [8:0] q[$];

  amd_decoder amd_decoder_inst (.mclk(mclk), .rstn(rstn), .ce(ce),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqFetch(reqFetch),
    .reqWrite(reqWrite), .reqPriv(reqPriv), .reqDebug(reqDebug),
    .sysProtDeny(sysProtDeny), .mpuEnable(mpuEnable),
    .rgnEnable(rgnEnable), .rgnBase(rgnBase), .rgnLast(rgnLast),
    .rgnAttr(rgnAttr), .irqIn(irqIn), .irqPrio(irqPrio),
    .vecBase(vecBase), .deepSleep(deepSleep), .reqReady(reqReady),
    .routeValid(routeValid), .routeSel(routeSel), .routeAddr(routeAddr),
    .sramAlias(sramAlias), .accessDone(accessDone),
    .faultFetch(faultFetch), .faultMpu(faultMpu), .faultSys(faultSys),
    .nvicIrq(nvicIrq), .wakeIrq(wakeIrq), .wakeReq(wakeReq),
    .irqPending(irqPending), .irqBestId(irqBestId),
    .irqBestPrio(irqBestPrio), .vecFetchAddr(vecFetchAddr));
  amd_memctl_model amd_memctl_model_inst (.reqAddr(reqAddr),
    .sysProtDeny(sysProtDeny));

  always #2.5 mclk = ~mclk;

  task chk(input [31:0] s, input [31:0] e);
    begin
      cmpCount = cmpCount + 1;
      if (s !== e)
      begin
        nErrors = nErrors + 1;
        $display("MISMATCH %0t seen %h want %h", $time, s, e);
      end
    end
  endtask

  task close_out;
    begin
      $display("errors %0d compares %0d", nErrors, cmpCount);
      if (nErrors == 0 && cmpCount > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  // k is {fetch, write, debug}; request stays up for back to back use
  task acc(input [31:0] a, input [2:0] k, input [8:0] e);
    begin
      reqAddr = a;
      {reqFetch, reqWrite, reqDebug} = k;
      reqValid = 1'h1;
      while (reqReady !== 1'h1)
        @(posedge mclk) #1;
      q.push_back(e);
      @(posedge mclk) #1;
    end
  endtask

  // --------
  // result watcher and timeout
  // --------
  always @(negedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 1000)
    begin
      nErrors = nErrors + 1;
      close_out;
    end
    if (accessDone === 1'h1)
      chk({routeSel, sramAlias, faultFetch, faultMpu, faultSys},
        q.size() ? q.pop_front() : 9'h1FF);
  end

  initial
  begin
    void'($urandom(32'h489D451F));
    repeat (20) @(posedge mclk);
    #1 rstn = 1'h1;
    acc(32'h00001000, 3'h4, IC);
    acc(32'h00001000, 3'h0, DC);
    acc(32'h00000100, 3'h5, DC);
    acc(32'h10000010, 3'h2, DC | AL);
    acc(32'h10000020, 3'h4, IC | AL);
    chk(routeAddr, 32'h20000020);
    acc(32'h20000040, 3'h0, SY);
    acc(32'h40001000, 3'h2, SY);
    acc(32'h5FFFFFFC, 3'h4, FF);
    acc(32'h60000000, 3'h4, SY);
    acc(32'h9FFFFFFC, 3'h4, SY);
    acc(32'hE0043FFF, 3'h0, PI);
    acc(32'hE0044000, 3'h2, PE);
    acc(32'hE00FFFFF, 3'h0, PE);
    acc(32'hE0100000, 3'h0, SY);
    acc(32'hFFFFFFFC, 3'h2, SY);
    acc(32'hE0000000, 3'h4, FF);
    acc(32'hE0100000, 3'h4, FF);
    acc(32'h20000000, 3'h4, FF);
    acc(32'hA0000000, 3'h4, FF);
    acc(32'hA0000000, 3'h0, SY);
    acc(32'h200F0000, 3'h0, FS);
    for (i = 0; i < 8; i = i + 1)
      acc($urandom & 32'h07FFFFFC, 3'h4, IC);
    rgnBase[31:0] = 32'h20000000;
    rgnLast[31:0] = 32'h2000FFFF;
    rgnAttr[2:0] = 3'h2;
    rgnAttr[23:21] = 3'h4;
    rgnBase[255:224] = 32'h20020000;
    rgnLast[255:224] = 32'h2002FFFF;
    rgnEnable = 8'h81;
    mpuEnable = 1'h1;
    acc(32'h20000010, 3'h0, SY);
    acc(32'h20000010, 3'h2, FM);
    acc(32'h20010000, 3'h0, FM);
    acc(32'h20020000, 3'h2, SY);
    reqPriv = 1'h0;
    acc(32'h20020004, 3'h0, FM);
    reqPriv = 1'h1;
    acc(32'h200F0000, 3'h0, FM | FS);
    reqValid = 1'h0;
    mpuEnable = 1'h0;
    repeat (4) @(posedge mclk) #1;
    chk(q.size(), 32'h0);
    $display("access test done");
    // handlers live in SRAM, clear of the private region
    vecBase = 32'h20000200;
    irqPrio = {96{1'h1}};
    irqPrio[29:27] = 3'h0;
    irqIn = 32'h00000208;
    repeat (2) @(posedge mclk);
    #1;
    chk({irqPending, irqBestId, irqBestPrio}, {1'h1, 5'h09, 3'h0});
    chk(vecFetchAddr, 32'h20000264);
    chk(nvicIrq & wakeIrq, irqIn);
    deepSleep = 1'h1;
    for (i = 0; i < 16; i = i + 1)
    begin
      irqIn = $urandom;
      @(posedge mclk) #1;
    end
    irqIn = 32'h80000000;
    repeat (2) @(posedge mclk);
    #1;
    chk(wakeReq, 32'h1);
    chk(vecFetchAddr, 32'h200002BC);
    // frozen fan-out keeps the last delivered lines
    ce = 1'h0;
    irqIn = 32'h00000001;
    repeat (2) @(posedge mclk);
    #1;
    chk(nvicIrq, 32'h80000000);
    ce = 1'h1;
    $display("irq test done");
    close_out;
  end
endmodule // test_amd_decoder
